/* cns_defs.svh */
`ifndef CNS_DEFS_SVH
`define CNS_DEFS_SVH
// register byte offsets
`define CNS_OFF_DCMP 8'h00
`define CNS_OFF_VEC 8'h04
`define CNS_OFF_FCTL 8'h08
`define CNS_OFF_FPTR 8'h0C
`define CNS_OFF_INTF 8'h10
`define CNS_OFF_INTE 8'h14
`define CNS_OFF_ERRC 8'h18
// field widths, limits, bit positions, masks and reset values
`define CNS_DCNT_W 5
`define CNS_DCNT_MAX 5'h11
`define CNS_DMA_BUFFER_COUNT_LSB 13
`define CNS_FSA_W 5
`define CNS_BO_BIT 13
`define CNS_TX_ERROR_PASSIVE_BIT 12
`define CNS_RX_ERROR_PASSIVE_BIT 11
`define CNS_TXW_BIT 10
`define CNS_RXW_BIT 9
`define CNS_EW_BIT 8
`define CNS_FLAG_MASK 8'hEF
`define CNS_FLAG_RST 8'h00
`define CNS_ENA_RST 8'h00
// interrupt codes
`define CNS_IC_ERR 7'h41
`define CNS_IC_WAKE 7'h42
`define CNS_IC_OVF 7'h43
`define CNS_IC_FIFO 7'h44
`define CNS_IC_NONE 7'h40
`define CNS_IC_RESV 7'h45
// error thresholds
`define CNS_WARN_LVL 9'd96
`define CNS_PASS_LVL 9'd128
`define CNS_BOFF_LVL 9'd256
`define CNS_ERR_MAX 9'h1FF
`endif

/* cns_pkg.sv */
package cns_pkg;
	typedef enum logic [1:0] {
		CNS_IDLE = 2'b01,
		CNS_ACK = 2'b10
	} cns_bus_e;
	typedef struct packed {
		cns_bus_e bus;
		logic ack;
		logic [31:0] dat;
		logic [4:0] dcnt;
		logic [2:0] dma_buffer_count;
		logic [4:0] fifo_start_buffer;
		logic [7:0] flags;
		logic [7:0] ena;
		logic [8:0] tec;
		logic [7:0] rec;
		logic [5:0] est;
		logic [6:0] interrupt_source_code;
		logic irq;
		logic [6:0] bcode;
	} cns_state_s;
endpackage : cns_pkg

/* cns_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cns_defs.svh"
module cns_regs #(
	parameter int unsigned NUM_BUF = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic init_mode_i,
	input wire logic listen_only_i,
	input wire logic tec_inc_i,
	input wire logic tec_dec_i,
	input wire logic rec_inc_i,
	input wire logic rec_dec_i,
	input wire logic invalid_msg_i,
	input wire logic wake_i,
	input wire logic fifo_almost_full_i,
	input wire logic rx_overflow_i,
	input wire logic rx_stored_i,
	input wire logic [4:0] rx_buf_i,
	input wire logic tx_done_i,
	input wire logic [4:0] tx_buf_i,
	input wire logic [4:0] matched_filter_number_i,
	input wire logic [5:0] fifo_write_pointer_i,
	input wire logic [5:0] fifo_read_pointer_i,
	output logic [4:0] data_bit_compare_count_o,
	output logic [2:0] dma_buffer_count_o,
	output logic [4:0] fifo_start_buffer_o,
	output logic tx_bus_off_o,
	output logic irq_o
);
	cns_pkg::cns_state_s st_ff;
	cns_pkg::cns_state_s nxt_st;

	// saturating counter step
	function automatic logic [8:0] cns_step(input logic [8:0] v, input logic inc,
		input logic dec, input logic [8:0] top);
		logic [8:0] r;
		r = v;
		if (inc && !dec && v != top)
			r = v + 9'd1;
		else if (dec && !inc && v != 9'd0)
			r = v - 9'd1;
		return r;
	endfunction : cns_step

	// byte-lane write merge for 16-bit registers
	function automatic logic [15:0] cns_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0])
			r[7:0] = d[7:0];
		if (s[1])
			r[15:8] = d[15:8];
		return r;
	endfunction : cns_merge

	logic [15:0] fctl_rd;
	logic [15:0] intf_rd;
	logic [15:0] fctl_wr;
	logic [15:0] intf_wr;
	logic [15:0] inte_wr;
	logic [15:0] dcmp_wr;
	logic wr_hit;
	logic [7:0] ev;
	logic [7:0] pend;
	logic [5:0] est_now;
	logic [8:0] rec_step;

	always_comb begin
		fctl_rd = {st_ff.dma_buffer_count, 8'h00, st_ff.fifo_start_buffer};
		intf_rd = {2'b00, st_ff.est, st_ff.flags & `CNS_FLAG_MASK};
		fctl_wr = cns_merge(fctl_rd, dat_i, sel_i);
		intf_wr = cns_merge(16'hFFFF, dat_i, sel_i);
		inte_wr = cns_merge({8'h00, st_ff.ena}, dat_i, sel_i);
		dcmp_wr = cns_merge({11'h000, st_ff.dcnt}, dat_i, sel_i);
		wr_hit = cyc_i && stb_i && we_i && (st_ff.bus == cns_pkg::CNS_IDLE);
	end

	always_comb begin
		nxt_st = st_ff;
		rec_step = {1'b0, st_ff.rec};
		ev = 8'h00;
		pend = 8'h00;
		est_now = 6'h00;
		// bus slave: one wait state, ack for one cycle
		case (st_ff.bus)
			cns_pkg::CNS_IDLE: begin
				nxt_st.ack = 1'b0;
				if (cyc_i && stb_i) begin
					nxt_st.bus = cns_pkg::CNS_ACK;
					nxt_st.ack = 1'b1;
					case (adr_i)
						`CNS_OFF_DCMP: nxt_st.dat = {27'h0, st_ff.dcnt};
						`CNS_OFF_VEC: nxt_st.dat = {19'h0, matched_filter_number_i, 1'b0,
							st_ff.interrupt_source_code};
						`CNS_OFF_FCTL: nxt_st.dat = {16'h0, fctl_rd};
						`CNS_OFF_FPTR: nxt_st.dat = {18'h0, fifo_write_pointer_i, 2'b00,
							fifo_read_pointer_i};
						`CNS_OFF_INTF: nxt_st.dat = {16'h0, intf_rd};
						`CNS_OFF_INTE: nxt_st.dat = {24'h0, st_ff.ena};
						`CNS_OFF_ERRC: nxt_st.dat = {16'h0, st_ff.tec[7:0], st_ff.rec};
						default: nxt_st.dat = 32'h0;
					endcase
				end
			end
			cns_pkg::CNS_ACK: begin
				nxt_st.bus = cns_pkg::CNS_IDLE;
				nxt_st.ack = 1'b0;
			end
			default: begin
				nxt_st.bus = cns_pkg::CNS_IDLE;
				nxt_st.ack = 1'b0;
			end
		endcase
		if (wr_hit) begin
			case (adr_i)
				`CNS_OFF_DCMP: begin
					if (dcmp_wr[4:0] <= `CNS_DCNT_MAX)
						nxt_st.dcnt = dcmp_wr[4:0];
				end
				`CNS_OFF_FCTL: begin
					if (fctl_wr[15:13] != 3'b111)
						nxt_st.dma_buffer_count = fctl_wr[15:13];
					nxt_st.fifo_start_buffer = fctl_wr[4:0];
				end
				`CNS_OFF_INTF: nxt_st.flags = st_ff.flags & intf_wr[7:0];
				`CNS_OFF_INTE: nxt_st.ena = inte_wr[7:0] & `CNS_FLAG_MASK;
				default: nxt_st.flags = nxt_st.flags;
			endcase
		end
		// error counters
		if (init_mode_i) begin
			nxt_st.tec = 9'h000;
			nxt_st.rec = 8'h00;
		end else if (!listen_only_i) begin
			nxt_st.tec = cns_step(st_ff.tec, tec_inc_i, tec_dec_i, `CNS_BOFF_LVL);
			rec_step = cns_step({1'b0, st_ff.rec}, rec_inc_i, rec_dec_i, 9'h0FF);
			nxt_st.rec = rec_step[7:0];
		end
		est_now[`CNS_BO_BIT - 8] = st_ff.tec >= `CNS_BOFF_LVL;
		est_now[`CNS_TX_ERROR_PASSIVE_BIT - 8] = st_ff.tec >= `CNS_PASS_LVL;
		est_now[`CNS_RX_ERROR_PASSIVE_BIT - 8] = {1'b0, st_ff.rec} >= `CNS_PASS_LVL;
		est_now[`CNS_TXW_BIT - 8] = st_ff.tec >= `CNS_WARN_LVL;
		est_now[`CNS_RXW_BIT - 8] = {1'b0, st_ff.rec} >= `CNS_WARN_LVL;
		est_now[`CNS_EW_BIT - 8] = est_now[2] | est_now[1];
		nxt_st.est = est_now;
		// events: set wins over software clear
		ev[7] = invalid_msg_i;
		ev[6] = wake_i;
		ev[5] = est_now != st_ff.est;
		ev[3] = fifo_almost_full_i;
		ev[2] = rx_overflow_i;
		ev[1] = rx_stored_i;
		ev[0] = tx_done_i;
		nxt_st.flags = (nxt_st.flags | ev) & `CNS_FLAG_MASK;
		if (rx_stored_i)
			nxt_st.bcode = {2'b00, rx_buf_i};
		else if (tx_done_i)
			nxt_st.bcode = {2'b00, tx_buf_i};
		pend = st_ff.flags & st_ff.ena;
		nxt_st.irq = pend != 8'h00;
		// priority error, wake, overflow, fifo, buffers, invalid message (reserved code), none
		if (pend[5])
			nxt_st.interrupt_source_code = `CNS_IC_ERR;
		else if (pend[6])
			nxt_st.interrupt_source_code = `CNS_IC_WAKE;
		else if (pend[2])
			nxt_st.interrupt_source_code = `CNS_IC_OVF;
		else if (pend[3])
			nxt_st.interrupt_source_code = `CNS_IC_FIFO;
		else if (pend[1] || pend[0])
			nxt_st.interrupt_source_code = st_ff.bcode;
		else if (pend[7])
			nxt_st.interrupt_source_code = `CNS_IC_RESV;
		else
			nxt_st.interrupt_source_code = `CNS_IC_NONE;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.bus <= cns_pkg::CNS_IDLE;
			st_ff.interrupt_source_code <= `CNS_IC_NONE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign dat_o = st_ff.dat;
	assign ack_o = st_ff.ack;
	assign data_bit_compare_count_o = st_ff.dcnt;
	assign dma_buffer_count_o = st_ff.dma_buffer_count;
	assign fifo_start_buffer_o = st_ff.fifo_start_buffer;
	assign tx_bus_off_o = st_ff.est[`CNS_BO_BIT - 8];
	assign irq_o = st_ff.irq;
endmodule : cns_regs
`default_nettype wire

/* cns_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module cns_regs_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire logic init_mode_i,
	input wire logic [4:0] data_bit_compare_count_o,
	input wire logic [2:0] dma_buffer_count_o,
	input wire logic [4:0] fifo_start_buffer_o,
	input wire logic tx_bus_off_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic w0, w8;
	assign w0 = cyc_i & stb_i & we_i & !ack_o & sel_i[0] & (adr_i == 8'h00);
	assign w8 = cyc_i & stb_i & we_i & !ack_o & (adr_i == 8'h08);
	chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	chk_ack_once: assert property (ack_o |=> !ack_o) else $error("ack too long");
	chk_cnt_take: assert property (w0 && dat_i[4:0] < 5'h12 |=>
		data_bit_compare_count_o == $past(dat_i[4:0])) else $error("count lost");
	chk_cnt_keep: assert property (w0 && dat_i[4:0] > 5'h11 |=>
		$stable(data_bit_compare_count_o)) else $error("bad count taken");
	chk_bufs_take: assert property (w8 && sel_i[1] && dat_i[15:13] != 3'h7 |=>
		dma_buffer_count_o == $past(dat_i[15:13])) else $error("buffers lost");
	chk_bufs_keep: assert property (w8 && sel_i[1] && dat_i[15:13] == 3'h7 |=>
		$stable(dma_buffer_count_o)) else $error("reserved taken");
	chk_fifo_start: assert property (w8 && sel_i[0] |=>
		fifo_start_buffer_o == $past(dat_i[4:0])) else $error("start lost");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !ack_o && !tx_bus_off_o)
		else $error("reset state");
	chk_init_clear: assert property (init_mode_i [*2] |=> !tx_bus_off_o)
		else $error("bus off in init");
endmodule : cns_regs_assertions
bind cns_regs cns_regs_assertions u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.cyc_i(cyc_i),
	.stb_i(stb_i),
	.we_i(we_i),
	.adr_i(adr_i),
	.sel_i(sel_i),
	.dat_i(dat_i),
	.ack_o(ack_o),
	.init_mode_i(init_mode_i),
	.data_bit_compare_count_o(data_bit_compare_count_o),
	.dma_buffer_count_o(dma_buffer_count_o),
	.fifo_start_buffer_o(fifo_start_buffer_o),
	.tx_bus_off_o(tx_bus_off_o),
	.irq_o(irq_o)
);
`default_nettype wire

/* cns_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cns_engine_model (
	input wire logic clk_i,
	output logic [9:0] ev_o
);
	initial ev_o = 10'h000;
	// n separate one-cycle events, each followed by an idle cycle
	task automatic pulse(input int k, input int n);
		repeat (n) begin
			ev_o[k] <= 1'h1;
			@(posedge clk_i);
			ev_o[k] <= 1'h0;
			@(posedge clk_i);
		end
	endtask : pulse
endmodule : cns_engine_model
`default_nettype wire

/* test_can_status_interrupt_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_can_status_interrupt_regs;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	logic init_mode_i = 1'h0, listen_only_i = 1'h0, ack_o, tx_bus_off_o, irq_o;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, r;
	logic [4:0] data_bit_compare_count_o, fifo_start_buffer_o, v, cnt, f;
	logic [4:0] rx_buf_i = 5'h00, tx_buf_i = 5'h00, matched_filter_number_i = 5'h00;
	logic [5:0] fifo_write_pointer_i = 6'h00, fifo_read_pointer_i = 6'h00;
	logic [2:0] dma_buffer_count_o, bc;
	logic [6:0] cc [6];
	wire [9:0] ev;
	int fails = 0, compares = 0, seed = 32'h5BD6;
	int kk [6] = '{4, 5, 6, 7, 8, 9};
	int bb [6] = '{7, 6, 3, 2, 1, 0};
	cns_engine_model eng (.clk_i, .ev_o(ev));
	cns_regs dut (.*, .tec_inc_i(ev[0]), .tec_dec_i(ev[1]), .rec_inc_i(ev[2]), .rec_dec_i(ev[3]),
		.invalid_msg_i(ev[4]), .wake_i(ev[5]), .fifo_almost_full_i(ev[6]),
		.rx_overflow_i(ev[7]), .rx_stored_i(ev[8]), .tx_done_i(ev[9]));
	initial forever #10 clk_i = ~clk_i;
	function automatic logic [31:0] vec(input logic [6:0] c);
		return {19'h0, matched_filter_number_i, 1'h0, c};
	endfunction : vec
	task automatic end_sim;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'h3};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 20);
		r = dat_o;
		{cyc_i, stb_i} <= 2'h0;
		@(posedge clk_i);
		if (n >= 20) begin
			fails++;
			end_sim;
		end
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'h0, a, 32'h0);
		chk(nm, e, r);
	endtask : rd
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		matched_filter_number_i <= 5'($random(seed));
		fifo_write_pointer_i <= 6'($random(seed));
		fifo_read_pointer_i <= 6'($random(seed));
		rx_buf_i <= 5'($random(seed));
		tx_buf_i <= 5'($random(seed));
		@(posedge clk_i);
		rd(8'h04, vec(7'h40), "vector");
		rd(8'h0C, {18'h0, fifo_write_pointer_i, 2'h0, fifo_read_pointer_i}, "pointers");
		rd(8'h14, 32'h0, "enables");
		rd(8'h18, 32'h0, "counts");
		rd(8'h1C, 32'h0, "unmapped");
		cnt = 5'h0;
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 5'h11 : (i == 1) ? 5'h12 : 5'($random(seed));
			wb(1'h1, 8'h00, 32'(v));
			if (v < 5'h12) cnt = v;
			rd(8'h00, 32'(cnt), "compare count");
			chk("count out", 32'(cnt), 32'(data_bit_compare_count_o));
		end
		bc = 3'h0;
		for (int d = 0; d < 8; d++) begin
			f = 5'($random(seed));
			wb(1'h1, 8'h08, {16'h0, 3'(d), 8'h0, f});
			if (d != 7) bc = 3'(d);
			rd(8'h08, {16'h0, bc, 8'h0, f}, "fifo setup");
			chk("buffers out", 32'(bc), 32'(dma_buffer_count_o));
			chk("start out", 32'(f), 32'(fifo_start_buffer_o));
		end
		$display("test setup registers done");
		wb(1'h1, 8'h14, 32'hEF);
		cc = '{7'h45, 7'h42, 7'h44, 7'h43, 7'(rx_buf_i), 7'(tx_buf_i)};
		for (int i = 0; i < 6; i++) begin
			eng.pulse(kk[i], 1);
			rd(8'h10, 32'(1 << bb[i]), "flag set");
			chk("irq on", 32'h1, 32'(irq_o));
			rd(8'h04, vec(cc[i]), "code");
			wb(1'h1, 8'h10, 32'hFF);
			wb(1'h1, 8'h14, 32'h0);
			chk("irq masked", 32'h0, 32'(irq_o));
			wb(1'h1, 8'h14, 32'hEF);
			rd(8'h10, 32'(1 << bb[i]), "flag kept");
			wb(1'h1, 8'h10, ~(32'h1 << bb[i]));
			rd(8'h10, 32'h0, "flag cleared");
		end
		eng.pulse(7, 1);
		eng.pulse(5, 1);
		rd(8'h10, 32'h44, "two flags");
		rd(8'h04, vec(7'h42), "priority");
		wb(1'h1, 8'h10, 32'h0);
		rd(8'h04, vec(7'h40), "no source");
		$display("test interrupts done");
		eng.pulse(0, 96);
		rd(8'h10, 32'h0520, "tx warning");
		rd(8'h04, vec(7'h41), "error code");
		listen_only_i <= 1'h1;
		eng.pulse(0, 5);
		eng.pulse(2, 5);
		listen_only_i <= 1'h0;
		rd(8'h18, 32'h6000, "frozen");
		eng.pulse(2, 96);
		eng.pulse(0, 32);
		rd(8'h18, 32'h8060, "counts");
		rd(8'h10, 32'h1720, "passive");
		eng.pulse(0, 128);
		rd(8'h00, 32'(cnt), "compare count");
		chk("bus off", 32'h1, 32'(tx_bus_off_o));
		init_mode_i <= 1'h1;
		@(posedge clk_i);
		rd(8'h18, 32'h0, "init counts");
		rd(8'h10, 32'h20, "init flags");
		chk("bus off", 32'h0, 32'(tx_bus_off_o));
		init_mode_i <= 1'h0;
		$display("test error counters done");
		end_sim;
	end
endmodule : test_can_status_interrupt_regs
`default_nettype wire
